// >>> rtl/uoef_consts.svh
/*
 * constants for the usb on-the-go event and error flag block:
 * register offsets, bit positions, reset values and timing counts.
 * assumes a 50 MHz peripheral clock and a byte-addressed plain register port.
 */
`ifndef UOEF_CONSTS_SVH
`define UOEF_CONSTS_SVH

// register byte offsets
`define UOEF_OFS_OTG_EVENT 8'h00
`define UOEF_OFS_ERROR 8'h04
`define UOEF_OFS_CONTROL 8'h08
`define UOEF_OFS_LINE 8'h0C

// otg event status bit positions
`define UOEF_BIT_ID 7
`define UOEF_BIT_MS 6
`define UOEF_BIT_LINE 5
`define UOEF_BIT_ACTV 4
`define UOEF_BIT_SESVD 3
`define UOEF_BIT_SESEND 2
`define UOEF_BIT_VBUS 0
`define UOEF_OTG_MASK 8'hFD

// error status bit positions
`define UOEF_BIT_PID 0
`define UOEF_BIT_TOKEOF 1
`define UOEF_BIT_TURN 4
`define UOEF_BIT_DMA 5
`define UOEF_ERR_MASK 8'h33

// reset values
`define UOEF_FLAGS_RST 8'h00
`define UOEF_ZERO32 32'h0000_0000

// timing
`define UOEF_CLK_HZ 50000000
`define UOEF_MS_TIME_US 1000
`define UOEF_MS_CYCLES ((`UOEF_CLK_HZ / 1000000) * `UOEF_MS_TIME_US)
`define UOEF_TURN_BITS 16

`endif

// >>> rtl/uoef_pkg.sv
/*
 * types for the usb on-the-go event and error flag block.
 * assumes the constants header is included by the design files.
 */
package uoef_pkg;

    // stable line state tracker
    typedef enum logic [2:0] {
        UOEF_LS_IDLE = 3'b001,
        UOEF_LS_WAIT = 3'b010,
        UOEF_LS_HOLD = 3'b100
    } uoef_ls_state_t;

endpackage

// >>> rtl/uoef_w1c_flags.sv
/*
 * a bank of hardware-set, write-one-to-clear flags.
 * assumes set pulses and the clear mask arrive synchronous to ref_clk.
 */
`include "uoef_consts.svh"

module uoef_w1c_flags
    import uoef_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL = '1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // set and clear
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    // flag state
    output logic [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // per bit: set wins over clear, a zero write leaves the bit alone
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_comb
        begin
            if (!IMPL[i])
                flags_d[i] = 1'b0;
            else if (set_i[i])
                flags_d[i] = 1'b1;
            else if (clr_i[i])
                flags_d[i] = 1'b0;
            else
                flags_d[i] = flags_q[i];
        end
    end

    // flag registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    assign flags_o = flags_q;

    a_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
        (set_i & IMPL) != '0 |=> (flags_q & $past(set_i & IMPL)) == $past(set_i & IMPL))
        else $error("set flag not held");

endmodule // uoef_w1c_flags

// >>> rtl/uoef_flags.sv
/*
 * usb on-the-go event and error status flags with a plain register port.
 * assumes all inputs synchronous to ref_clk, event inputs one-cycle pulses
 * from the usb engine, and comparator/pin inputs as clean levels.
 */
// Functional notes
// - Unimplemented event bits always read zero
// - Hardware-set flags, reset zero, write-one clears
// - ID pin change sets id flag
// - Millisecond timer expiry sets timer flag
// - Line stable 1 ms, differs: set
// - Wake-up bus activity sets activity flag
// - Vbus below session end sets flag
// - Session end comparator change sets flag
// - Session valid comparator change sets flag
// - Device mode: token crc5 failure sets bit1
// - Host mode: bit1 is end-of-frame error
// - Pid check failure sets bit0
// - Late bus grant sets memory error
// - Truncated receive buffer sets memory error
// - Over 16 idle bit times: turnaround timeout
// - Error flag reads one after detection
`include "uoef_consts.svh"

module uoef_flags
    import uoef_pkg::*;
#(
    parameter int MS_CYCLES = `UOEF_MS_CYCLES,
    parameter int TURN_BITS = `UOEF_TURN_BITS
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // cable and comparator levels
    input wire logic id_pin,
    input wire logic [1:0] line_state,
    input wire logic sess_end_cmp,
    input wire logic sess_valid_cmp,
    input wire logic vbus_below_end,
    input wire logic wake_activity,
    // packet engine events
    input wire logic bit_tick,
    input wire logic eop_seen,
    input wire logic resp_seen,
    input wire logic token_crc5_bad,
    input wire logic busy_xfer,
    input wire logic sof_zero,
    input wire logic pid_check_bad,
    input wire logic bus_grant_late,
    input wire logic rx_truncated,
    // status
    output logic host_mode,
    output logic turn_wait
);

    ////////////////////////////////////////////////////////////////////////////////
    // level history for change detection

    logic id_q;
    logic id_d;
    logic se_q;
    logic se_d;
    logic sv_q;
    logic sv_d;
    logic vb_q;
    logic vb_d;
    logic hist_ok_q;
    logic hist_ok_d;

    always_comb
    begin
        id_d = id_pin;
        se_d = sess_end_cmp;
        sv_d = sess_valid_cmp;
        vb_d = vbus_below_end;
        hist_ok_d = 1'b1;
    end

    // history registers; the first cycle after reset sees no change
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            id_q <= 1'b0;
            se_q <= 1'b0;
            sv_q <= 1'b0;
            vb_q <= 1'b0;
            hist_ok_q <= 1'b0;
        end
        else
        begin
            id_q <= id_d;
            se_q <= se_d;
            sv_q <= sv_d;
            vb_q <= vb_d;
            hist_ok_q <= hist_ok_d;
        end
    end

    logic id_chg;
    logic se_chg;
    logic sv_chg;
    logic vb_fall;

    assign id_chg = hist_ok_q && (id_pin != id_q);
    assign se_chg = hist_ok_q && (sess_end_cmp != se_q);
    assign sv_chg = hist_ok_q && (sess_valid_cmp != sv_q);
    assign vb_fall = hist_ok_q && vbus_below_end && !vb_q;

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond timer

    logic [31:0] ms_cnt_q;
    logic [31:0] ms_cnt_d;
    logic ms_tick;

    assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

    always_comb
    begin
        ms_cnt_d = ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ms_cnt_q <= `UOEF_ZERO32;
        else
            ms_cnt_q <= ms_cnt_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line state stability tracker

    uoef_ls_state_t ls_st_q;
    uoef_ls_state_t ls_st_d;
    logic [31:0] ls_cnt_q;
    logic [31:0] ls_cnt_d;
    logic [1:0] ls_cur_q;
    logic [1:0] ls_cur_d;
    logic [1:0] ls_stable_q;
    logic [1:0] ls_stable_d;
    logic ls_set;

    always_comb
    begin
        ls_st_d = ls_st_q;
        ls_cnt_d = ls_cnt_q;
        ls_cur_d = line_state;
        ls_stable_d = ls_stable_q;
        ls_set = 1'b0;
        unique case (ls_st_q)
            UOEF_LS_IDLE:
            begin
                ls_cnt_d = `UOEF_ZERO32;
                ls_st_d = UOEF_LS_WAIT;
            end
            UOEF_LS_WAIT:
            begin
                if (line_state != ls_cur_q)
                    ls_cnt_d = `UOEF_ZERO32;
                else if (ls_cnt_q == 32'(MS_CYCLES - 1))
                begin
                    ls_st_d = UOEF_LS_HOLD;
                    if (ls_cur_q != ls_stable_q)
                    begin
                        ls_set = 1'b1;
                        ls_stable_d = ls_cur_q;
                    end
                end
                else
                    ls_cnt_d = ls_cnt_q + 32'h0000_0001;
            end
            UOEF_LS_HOLD:
            begin
                if (line_state != ls_cur_q)
                begin
                    ls_cnt_d = `UOEF_ZERO32;
                    ls_st_d = UOEF_LS_WAIT;
                end
            end
            default:
                ls_st_d = UOEF_LS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ls_st_q <= UOEF_LS_IDLE;
            ls_cnt_q <= `UOEF_ZERO32;
            ls_cur_q <= 2'h0;
            ls_stable_q <= 2'h0;
        end
        else
        begin
            ls_st_q <= ls_st_d;
            ls_cnt_q <= ls_cnt_d;
            ls_cur_q <= ls_cur_d;
            ls_stable_q <= ls_stable_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // turnaround timeout: idle bit times counted after end of packet

    logic [7:0] turn_cnt_q;
    logic [7:0] turn_cnt_d;
    logic turn_act_q;
    logic turn_act_d;
    logic turn_to;

    assign turn_to = turn_act_q && bit_tick && (turn_cnt_q == 8'(TURN_BITS));

    always_comb
    begin
        turn_act_d = turn_act_q;
        turn_cnt_d = turn_cnt_q;
        if (eop_seen)
        begin
            turn_act_d = 1'b1;
            turn_cnt_d = 8'h00;
        end
        else if (resp_seen || turn_to)
            turn_act_d = 1'b0;
        else if (turn_act_q && bit_tick)
            turn_cnt_d = turn_cnt_q + 8'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            turn_act_q <= 1'b0;
            turn_cnt_q <= 8'h00;
        end
        else
        begin
            turn_act_q <= turn_act_d;
            turn_cnt_q <= turn_cnt_d;
        end
    end

    assign turn_wait = turn_act_q;

    ////////////////////////////////////////////////////////////////////////////////
    // registers: control (host mode) and flag banks

    logic host_q;
    logic host_d;
    logic wr_otg;
    logic wr_err;
    logic [7:0] otg_set;
    logic [7:0] err_set;
    logic [7:0] otg_flags;
    logic [7:0] err_flags;

    assign wr_otg = reg_wr && (reg_addr == `UOEF_OFS_OTG_EVENT);
    assign wr_err = reg_wr && (reg_addr == `UOEF_OFS_ERROR);

    always_comb
    begin
        host_d = host_q;
        if (reg_wr && (reg_addr == `UOEF_OFS_CONTROL))
            host_d = reg_wdata[0];
        otg_set = 8'h00;
        otg_set[`UOEF_BIT_ID] = id_chg;
        otg_set[`UOEF_BIT_MS] = ms_tick;
        otg_set[`UOEF_BIT_LINE] = ls_set;
        otg_set[`UOEF_BIT_ACTV] = wake_activity;
        otg_set[`UOEF_BIT_SESVD] = vb_fall;
        otg_set[`UOEF_BIT_SESEND] = se_chg;
        otg_set[`UOEF_BIT_VBUS] = sv_chg;
        err_set = 8'h00;
        err_set[`UOEF_BIT_PID] = pid_check_bad;
        // bit 1 meaning depends on role
        err_set[`UOEF_BIT_TOKEOF] = host_q ? (busy_xfer && sof_zero)
                                           : token_crc5_bad;
        err_set[`UOEF_BIT_TURN] = turn_to;
        err_set[`UOEF_BIT_DMA] = bus_grant_late || rx_truncated;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            host_q <= 1'b0;
        else
            host_q <= host_d;
    end

    assign host_mode = host_q;

    // sticky banks with set-over-clear
    uoef_w1c_flags #(.WIDTH(8), .IMPL(`UOEF_OTG_MASK)) u_otg (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_i(otg_set),
        .clr_i(wr_otg ? reg_wdata[7:0] : 8'h00),
        .flags_o(otg_flags)
    );

    uoef_w1c_flags #(.WIDTH(8), .IMPL(`UOEF_ERR_MASK)) u_err (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_i(err_set),
        .clr_i(wr_err ? reg_wdata[7:0] : 8'h00),
        .flags_o(err_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb
    begin
        rdata_d = `UOEF_ZERO32;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `UOEF_OFS_OTG_EVENT: rdata_d = {24'h000000, otg_flags};
                `UOEF_OFS_ERROR: rdata_d = {24'h000000, err_flags};
                `UOEF_OFS_CONTROL: rdata_d = {31'h00000000, host_q};
                `UOEF_OFS_LINE: rdata_d = {28'h0000000, ls_stable_q, line_state};
                default: rdata_d = `UOEF_ZERO32;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rdata_q <= `UOEF_ZERO32;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_otg_unimpl: assert property (@(posedge ref_clk) disable iff (rst)
        (otg_flags[1] == 1'b0) && (rdata_q[31:8] == 24'h000000))
        else $error("unimplemented bits not zero");
    a_id_change: assert property (@(posedge ref_clk) disable iff (rst)
        id_chg |=> otg_flags[`UOEF_BIT_ID])
        else $error("id change not flagged");
    a_ms_flag: assert property (@(posedge ref_clk) disable iff (rst)
        ms_tick |=> otg_flags[`UOEF_BIT_MS])
        else $error("ms flag not set");
    a_line_stable: assert property (@(posedge ref_clk) disable iff (rst)
        ls_set |=> otg_flags[`UOEF_BIT_LINE] && (ls_stable_q == $past(ls_cur_q)))
        else $error("line stable flag wrong");
    a_activity_set: assert property (@(posedge ref_clk) disable iff (rst)
        wake_activity |=> otg_flags[`UOEF_BIT_ACTV])
        else $error("activity flag not set");
    a_vbus_fall: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(vbus_below_end) && hist_ok_q |=> otg_flags[`UOEF_BIT_SESVD])
        else $error("session valid flag not set");
    a_sess_end: assert property (@(posedge ref_clk) disable iff (rst)
        hist_ok_q && $changed(sess_end_cmp) |=> otg_flags[`UOEF_BIT_SESEND])
        else $error("session end flag not set");
    a_sess_valid: assert property (@(posedge ref_clk) disable iff (rst)
        hist_ok_q && $changed(sess_valid_cmp) |=> otg_flags[`UOEF_BIT_VBUS])
        else $error("session valid change not set");
    a_token_crc: assert property (@(posedge ref_clk) disable iff (rst)
        !host_q && token_crc5_bad |=> err_flags[`UOEF_BIT_TOKEOF])
        else $error("crc5 error not flagged");
    a_eof_err: assert property (@(posedge ref_clk) disable iff (rst)
        host_q && busy_xfer && sof_zero |=> err_flags[`UOEF_BIT_TOKEOF])
        else $error("eof error not flagged");
    a_pid_err: assert property (@(posedge ref_clk) disable iff (rst)
        pid_check_bad |=> err_flags[`UOEF_BIT_PID])
        else $error("pid error not flagged");
    a_mem_err: assert property (@(posedge ref_clk) disable iff (rst)
        bus_grant_late || rx_truncated |=> err_flags[`UOEF_BIT_DMA])
        else $error("memory error not flagged");
    a_turn_timeout: assert property (@(posedge ref_clk) disable iff (rst)
        turn_to |-> turn_cnt_q == 8'(TURN_BITS) ##1 err_flags[`UOEF_BIT_TURN])
        else $error("turnaround timeout wrong");
    a_err_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        err_flags[`UOEF_BIT_PID] && !wr_err |=> err_flags[`UOEF_BIT_PID])
        else $error("error flag lost");
    a_w1c_clear: assert property (@(posedge ref_clk) disable iff (rst)
        wr_otg && reg_wdata[`UOEF_BIT_MS] && !ms_tick |=> !otg_flags[`UOEF_BIT_MS])
        else $error("write one did not clear");

    c_clear_race: cover property (@(posedge ref_clk) wr_err && reg_wdata[0] && pid_check_bad);
    c_line_set: cover property (@(posedge ref_clk) ls_set);
    c_turn_out: cover property (@(posedge ref_clk) turn_to);
    c_host_eof: cover property (@(posedge ref_clk) host_q && busy_xfer && sof_zero);

endmodule // uoef_flags

// >>> verif/uoef_cable_model.sv
/*
 * far-side cable model: drives the cable id, line state and vbus comparator
 * levels seen by the flag block.
 * assumes the bench calls its tasks and shares ref_clk with the block.
 */
module uoef_cable_model
(
    // clock
    input wire logic ref_clk,
    // cable and comparator levels
    output logic id_pin,
    output logic [1:0] line_state,
    output logic sess_end_cmp,
    output logic sess_valid_cmp,
    output logic vbus_below_end,
    output logic wake_activity
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet cable at power-up
    initial
    begin
        id_pin = 1'b0;
        line_state = 2'b00;
        sess_end_cmp = 1'b0;
        sess_valid_cmp = 1'b0;
        vbus_below_end = 1'b0;
        wake_activity = 1'b0;
    end

    // hold a new differential line state
    task automatic set_line(input logic [1:0] v);
        @(posedge ref_clk);
        line_state <= v;
    endtask

    // one cable event: levels toggle and stay, wake and vbus drop last one cycle
    task automatic kick(input int k);
        @(posedge ref_clk);
        case (k)
            0: id_pin <= ~id_pin;
            1: sess_end_cmp <= ~sess_end_cmp;
            2: sess_valid_cmp <= ~sess_valid_cmp;
            3: vbus_below_end <= 1'b1;
            default: wake_activity <= 1'b1;
        endcase
        @(posedge ref_clk);
        vbus_below_end <= 1'b0;
        wake_activity <= 1'b0;
    endtask
endmodule // uoef_cable_model

// >>> verif/uoef_flags_tb.sv
/*
 * self-checking bench for the usb event and error flag block.
 * assumes the cable model beside it and a shortened millisecond count.
 */
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module uoef_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MS = 200;
    logic ref_clk, rst, reg_wr, reg_rd, bit_tick, eop_seen, resp_seen, token_crc5_bad;
    logic busy_xfer, sof_zero, pid_check_bad, bus_grant_late, rx_truncated;
    logic host_mode, turn_wait, id_pin, sess_end_cmp, sess_valid_cmp, vbus_below_end;
    logic wake_activity;
    logic [1:0] line_state;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, m;
    int num_errors, n_checks;
    time t1, t2;
    logic [7:0] ev_adr [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04};
    logic [31:0] ev_bit [0:8] = '{32'h80, 32'h04, 32'h01, 32'h08, 32'h10, 32'h01, 32'h02,
        32'h20, 32'h20};

    ////////////////////////////////////////////////////////////////////////////////
    // design and far side
    uoef_flags #(.MS_CYCLES(MS), .TURN_BITS(16)) i_dut
    (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .id_pin(id_pin),
        .line_state(line_state), .sess_end_cmp(sess_end_cmp),
        .sess_valid_cmp(sess_valid_cmp), .vbus_below_end(vbus_below_end),
        .wake_activity(wake_activity), .bit_tick(bit_tick), .eop_seen(eop_seen),
        .resp_seen(resp_seen), .token_crc5_bad(token_crc5_bad), .busy_xfer(busy_xfer),
        .sof_zero(sof_zero), .pid_check_bad(pid_check_bad), .bus_grant_late(bus_grant_late),
        .rx_truncated(rx_truncated), .host_mode(host_mode), .turn_wait(turn_wait)
    );

    uoef_cable_model i_cable
    (
        .ref_clk(ref_clk), .id_pin(id_pin), .line_state(line_state),
        .sess_end_cmp(sess_end_cmp), .sess_valid_cmp(sess_valid_cmp),
        .vbus_below_end(vbus_below_end), .wake_activity(wake_activity)
    );

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // register port tasks: one-cycle strobes, read data the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // one event: 0..4 from the cable, 5..10 one-cycle packet engine pulses
    task automatic fire(input int i);
        if (i < 5)
            i_cable.kick(i);
        else
        begin
            @(posedge ref_clk);
            case (i)
                5: pid_check_bad <= 1'b1;
                6: token_crc5_bad <= 1'b1;
                7: bus_grant_late <= 1'b1;
                8: rx_truncated <= 1'b1;
                9: eop_seen <= 1'b1;
                default: resp_seen <= 1'b1;
            endcase
            @(posedge ref_clk);
            {pid_check_bad, token_crc5_bad, bus_grant_late, rx_truncated} <= 4'h0;
            {eop_seen, resp_seen} <= 2'h0;
        end
    endtask

    // usb bit times, one tick every second cycle
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            bit_tick <= 1'b1;
            @(posedge ref_clk);
            bit_tick <= 1'b0;
        end
    endtask

    // poll for the millisecond flag under a bounded count
    task automatic wait_ms(output time t);
        logic [31:0] v;
        for (int k = 0; k < MS; k++)
        begin
            rd(8'h00, v);
            if (v[6] === 1'b1)
            begin
                t = $time;
                return;
            end
        end
        num_errors++;
        end_of_test();
    endtask

    task end_of_test;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {ref_clk, reg_wr, reg_rd, bit_tick, eop_seen, resp_seen, token_crc5_bad} = 7'h00;
        {busy_xfer, sof_zero, pid_check_bad, bus_grant_late, rx_truncated} = 5'h00;
        {reg_addr, reg_wdata, num_errors, n_checks} = '0;
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values, unused bits and an unmapped place
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, d);
        `CHK(d & 32'hFFFF_FFBF, 32'h0000_0000)
        rd(8'h04, d);
        `CHK(d, 32'h0000_0000)
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, d);
        `CHK(d, 32'h0000_0000)
        `CHK({host_mode, turn_wait}, 2'b00)
        // each of the nine cable and packet engine events sets its flag, survives a zero write, clears on a one
        for (int i = 0; i < 9; i++)
        begin
            m = (ev_adr[i] == 8'h00) ? 32'hFFFF_FFBF : 32'hFFFF_FFFF;
            fire(i);
            rd(ev_adr[i], d);
            `CHK(d & m, ev_bit[i])
            wr(ev_adr[i], 32'h0000_0000);
            rd(ev_adr[i], d);
            `CHK(d & m, ev_bit[i])
            wr(ev_adr[i], ev_bit[i]);
            rd(ev_adr[i], d);
            `CHK(d & m, 32'h0000_0000)
        end
        // a set in the cycle of its clear wins
        @(posedge ref_clk);
        {pid_check_bad, reg_wr, reg_addr, reg_wdata} <= {2'h3, 8'h04, 32'h1};
        @(posedge ref_clk);
        {pid_check_bad, reg_wr} <= 2'h0;
        rd(8'h04, d);
        `CHK(d, 32'h0000_0001)
        wr(8'h04, 32'h0000_0001);
        // host mode: bit 1 means end of frame, a token check failure is ignored
        wr(8'h08, 32'h0000_0001);
        rd(8'h08, d);
        `CHK({d, host_mode}, {32'h1, 1'b1})
        fire(6);
        rd(8'h04, d);
        `CHK(d, 32'h0000_0000)
        @(posedge ref_clk);
        {busy_xfer, sof_zero} <= 2'h3;
        @(posedge ref_clk);
        {busy_xfer, sof_zero} <= 2'h0;
        rd(8'h04, d);
        `CHK(d, 32'h0000_0002)
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_0000);
        // turnaround: sixteen idle bit times are fine, the seventeenth is not
        fire(9);
        tick(16);
        rd(8'h04, d);
        `CHK({d, turn_wait}, {32'h0, 1'b1})
        tick(1);
        rd(8'h04, d);
        `CHK(d, 32'h0000_0010)
        wr(8'h04, 32'h0000_0010);
        fire(9);
        tick(10);
        fire(10);
        tick(10);
        rd(8'h04, d);
        `CHK({d, turn_wait}, {32'h0, 1'b0})
        // line state: stable 1 ms and new sets, a return to the recorded state does not
        i_cable.set_line(2'b01);
        repeat (MS / 2) @(posedge ref_clk);
        rd(8'h00, d);
        `CHK(d[5], 1'b0)
        repeat (MS) @(posedge ref_clk);
        rd(8'h00, d);
        `CHK(d[5], 1'b1)
        rd(8'h0C, d);
        `CHK(d, 32'h0000_0005)
        wr(8'h00, 32'h0000_0020);
        i_cable.set_line(2'b10);
        repeat (5) @(posedge ref_clk);
        i_cable.set_line(2'b01);
        repeat (MS + 20) @(posedge ref_clk);
        rd(8'h00, d);
        `CHK(d[5], 1'b0)
        // millisecond timer period: drop the stale flag so both stamps are fresh expiries
        wr(8'h00, 32'h0000_0040);
        wait_ms(t1);
        wr(8'h00, 32'h0000_0040);
        wait_ms(t2);
        `CHK((t2 - t1) / 20 >= MS - 3 && (t2 - t1) / 20 <= MS + 3, 1'b1)
        end_of_test();
    end
endmodule // uoef_flags_tb
